// File: rtl/ugps_defines.svh
// Purpose: constants of the uart pin function select block
// Assumes: 8-bit registers, address = {channel, register index}
// Notes:   definitions only
`ifndef UGPS_DEFINES_SVH
`define UGPS_DEFINES_SVH

// geometry
`define UGPS_NUM_CHAN      4
`define UGPS_PINS_PER_CHAN 4
`define UGPS_DATA_W        8

// register index within a channel
`define UGPS_REG_GPIO_CFG  4'h0
`define UGPS_REG_GPIO_DATA 4'h1
`define UGPS_REG_INT_EN    4'h2
`define UGPS_REG_INT_STS   4'h3
`define UGPS_REG_INT_CLR   4'h4
`define UGPS_REG_LINE_CTL  4'h5
`define UGPS_REG_TX_SYNC   4'h6
`define UGPS_REG_TIMER_UP  4'h7
`define UGPS_REG_CLK_SRC   4'h8
`define UGPS_REG_STATUS    4'h9

// field positions
`define UGPS_FUNC_SEL_BIT  7
`define UGPS_RTS_LVL_BIT   1
`define UGPS_STS_CTS_BIT   0
`define UGPS_STS_RX_BIT    1
`define UGPS_INT_CTS_BIT   4

// dedicated pin slots in a group
`define UGPS_REFCLK_PIN    0
`define UGPS_TIMER_PIN     1

// reset of a channel config: all pins inputs, rts pin high
`define UGPS_CFG_RST       21'h000008
`define UGPS_STS_RST       5'h00

`endif

// File: rtl/ugps_pkg.sv
// Purpose: types of the uart pin function select block
// Assumes: constants live in ugps_defines.svh
// Notes:   config struct is one channel's software state
package ugps_pkg;

  // register bus address split
  typedef struct packed {
    logic [1:0] chan;
    logic [3:0] reg_idx;
  } ugps_addr_t;

  // one channel's software-set configuration
  typedef struct packed {
    logic [3:0] dir;        // 1 = output
    logic [3:0] od;         // 1 = open drain
    logic [3:0] val;        // output value
    logic [4:0] int_en;     // [3:0] pins, [4] cts
    logic       rts_level;  // pin level of rts
    logic       refclk_sel; // pin 0 -> reference clock
    logic       timer_sel;  // pin 1 -> timer
    logic       clksrc_sel; // rts -> baud clock
  } ugps_chan_cfg_t;

endpackage : ugps_pkg

// File: rtl/ugps_pin_select.sv
// Purpose: pin function select for a four-channel uart bridge
// Assumes: sources on same clock; pins asynchronous
// Notes:   all pins registered once before leaving
//
// Contract
// - each gpio pin: input, push-pull, open-drain
// - each gpio pin can raise an event interrupt
// - tx sync bit 7 puts refclk on pin 0
// - timer upper bit 7 puts timer on pin 1
// - rts pin follows software line control level
// - clock source bit 7 puts clock on rts
// - far side drives cts; device samples it
// - each channel has its own tx output
// - every channel's pin 0 can output its own refclk
`timescale 1ns/1ps
`include "ugps_defines.svh"

module ugps_pin_select #(
  parameter int NUM_CHAN = `UGPS_NUM_CHAN,
  parameter int PINS     = `UGPS_PINS_PER_CHAN
) (
  input  wire logic                       CORE_CLK,
  input  wire logic                       RESET,
  input  wire ugps_pkg::ugps_addr_t       ADDR,
  input  wire logic [`UGPS_DATA_W-1:0]    WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic      [`UGPS_DATA_W-1:0]    RDATA,
  input  wire logic [NUM_CHAN-1:0]        TX_DATA,
  input  wire logic [NUM_CHAN-1:0]        REF_CLK,
  input  wire logic [NUM_CHAN-1:0]        TIMER_OUT,
  input  wire logic [NUM_CHAN-1:0]        BAUD_CLK,
  output logic      [NUM_CHAN-1:0]        TX,
  output logic      [NUM_CHAN-1:0]        RTS_N,
  input  wire logic [NUM_CHAN-1:0]        CTS_N,
  input  wire logic [NUM_CHAN-1:0]        RX,
  output logic      [NUM_CHAN-1:0]        CTS_N_CORE,
  output logic      [NUM_CHAN-1:0]        RX_CORE,
  input  wire logic [NUM_CHAN*PINS-1:0]   GPIO_IN,
  output logic      [NUM_CHAN*PINS-1:0]   GPIO_OUT,
  output logic      [NUM_CHAN*PINS-1:0]   GPIO_OE_N,
  output logic                            IRQ
);
  import ugps_pkg::*;

  // group slices below are four pins wide, so PINS stays at four
  localparam int NPIN = NUM_CHAN * PINS;

  // software state
  ugps_chan_cfg_t          cfg_ff     [NUM_CHAN];
  ugps_chan_cfg_t          nxt_cfg    [NUM_CHAN];
  logic [4:0]              sts_ff     [NUM_CHAN];
  logic [4:0]              nxt_sts    [NUM_CHAN];
  logic [`UGPS_DATA_W-1:0] rdata_ff;
  logic [`UGPS_DATA_W-1:0] nxt_rdata;
  logic                    irq_ff;
  logic                    nxt_irq;

  // pin synchronisers and edge history
  logic [NPIN-1:0]         gpio_meta_ff;
  logic [NPIN-1:0]         gpio_sync_ff;
  logic [NPIN-1:0]         gpio_prev_ff;
  logic [NUM_CHAN-1:0]     cts_meta_ff;
  logic [NUM_CHAN-1:0]     cts_sync_ff;
  logic [NUM_CHAN-1:0]     cts_prev_ff;
  logic [NUM_CHAN-1:0]     rx_meta_ff;
  logic [NUM_CHAN-1:0]     rx_sync_ff;

  // pin drivers
  logic [NPIN-1:0]         gpio_out_ff;
  logic [NPIN-1:0]         nxt_gpio_out;
  logic [NPIN-1:0]         gpio_oe_n_ff;
  logic [NPIN-1:0]         nxt_gpio_oe_n;
  logic [NUM_CHAN-1:0]     tx_ff;
  logic [NUM_CHAN-1:0]     nxt_tx;
  logic [NUM_CHAN-1:0]     rts_n_ff;
  logic [NUM_CHAN-1:0]     nxt_rts_n;

  // two flops per pin before anything looks at it
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      // gpio lines rest low on their pull-downs
      gpio_meta_ff <= '0;
      gpio_sync_ff <= '0;
      gpio_prev_ff <= '0;
      // cts and rx rest high, so release makes no false edge
      cts_meta_ff  <= '1;
      cts_sync_ff  <= '1;
      cts_prev_ff  <= '1;
      rx_meta_ff   <= '1;
      rx_sync_ff   <= '1;
    end else begin
      gpio_meta_ff <= GPIO_IN;
      gpio_sync_ff <= gpio_meta_ff;
      // history flop for the edge detector
      gpio_prev_ff <= gpio_sync_ff;
      cts_meta_ff  <= CTS_N;
      cts_sync_ff  <= cts_meta_ff;
      cts_prev_ff  <= cts_sync_ff;
      rx_meta_ff   <= RX;
      rx_sync_ff   <= rx_meta_ff;
    end
  end

  // register writes, sticky status and interrupt
  always_comb begin
    logic [3:0] pin_edge;
    logic       cts_edge;
    logic       hit;
    logic [3:0] out_mask;
    pin_edge = 4'h0;
    cts_edge = 1'b0;
    hit      = 1'b0;
    out_mask = 4'h0;
    nxt_irq  = 1'b0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      nxt_cfg[c] = cfg_ff[c];
      nxt_sts[c] = sts_ff[c];
      // only the addressed channel takes the write
      hit = WR && (int'(ADDR.chan) == c);
      if (hit) begin
        unique case (ADDR.reg_idx)
          `UGPS_REG_GPIO_CFG: begin
            nxt_cfg[c].dir = WDATA[3:0];
            nxt_cfg[c].od  = WDATA[7:4];
          end
          `UGPS_REG_GPIO_DATA: begin
            nxt_cfg[c].val = WDATA[3:0];
          end
          `UGPS_REG_INT_EN: begin
            nxt_cfg[c].int_en = WDATA[4:0];
          end
          `UGPS_REG_INT_CLR: begin
            nxt_sts[c] = sts_ff[c] & ~WDATA[4:0];
          end
          `UGPS_REG_LINE_CTL: begin
            nxt_cfg[c].rts_level = WDATA[`UGPS_RTS_LVL_BIT];
          end
          `UGPS_REG_TX_SYNC: begin
            nxt_cfg[c].refclk_sel = WDATA[`UGPS_FUNC_SEL_BIT];
          end
          `UGPS_REG_TIMER_UP: begin
            nxt_cfg[c].timer_sel = WDATA[`UGPS_FUNC_SEL_BIT];
          end
          `UGPS_REG_CLK_SRC: begin
            nxt_cfg[c].clksrc_sel = WDATA[`UGPS_FUNC_SEL_BIT];
          end
          `UGPS_REG_INT_STS, `UGPS_REG_STATUS: begin
            // read-only: the write is dropped
            nxt_cfg[c] = cfg_ff[c];
          end
          default: begin
            // unmapped: write ignored
            nxt_cfg[c] = cfg_ff[c];
          end
        endcase
      end
      // a pin the device drives, gpio or dedicated, is an output
      // its own toggling would otherwise flood the status
      out_mask = cfg_ff[c].dir;
      out_mask[`UGPS_REFCLK_PIN] = cfg_ff[c].dir[`UGPS_REFCLK_PIN] | cfg_ff[c].refclk_sel;
      out_mask[`UGPS_TIMER_PIN]  = cfg_ff[c].dir[`UGPS_TIMER_PIN] | cfg_ff[c].timer_sel;
      // any edge on an input pin is an event
      pin_edge = (gpio_sync_ff[c*PINS +: 4] ^ gpio_prev_ff[c*PINS +: 4])
                 & ~out_mask;
      cts_edge = cts_sync_ff[c] ^ cts_prev_ff[c];
      // set wins over a clear in the same cycle
      nxt_sts[c] = nxt_sts[c] | {cts_edge, pin_edge};
      // enabled sticky bits raise the level interrupt
      nxt_irq = nxt_irq | (|(sts_ff[c] & cfg_ff[c].int_en));
    end
  end

  // configuration and sticky status registers
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        cfg_ff[c] <= ugps_chan_cfg_t'(`UGPS_CFG_RST);
        sts_ff[c] <= `UGPS_STS_RST;
      end
      irq_ff <= 1'b0;
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        cfg_ff[c] <= nxt_cfg[c];
        sts_ff[c] <= nxt_sts[c];
      end
      irq_ff <= nxt_irq;
    end
  end

  // read data valid only in the cycle after the strobe
  // gating on the strobe keeps the bus at zero between answers
  always_comb begin
    int c;
    c = int'(ADDR.chan);
    nxt_rdata = 8'h00;
    if (RD && c < NUM_CHAN) begin
      unique case (ADDR.reg_idx)
        `UGPS_REG_GPIO_CFG: begin
          nxt_rdata = {cfg_ff[c].od, cfg_ff[c].dir};
        end
        `UGPS_REG_GPIO_DATA: begin
          // reads the pin level, not the written value
          nxt_rdata[3:0] = gpio_sync_ff[c*PINS +: 4];
        end
        `UGPS_REG_INT_EN: begin
          nxt_rdata[4:0] = cfg_ff[c].int_en;
        end
        `UGPS_REG_INT_STS: begin
          nxt_rdata[4:0] = sts_ff[c];
        end
        `UGPS_REG_LINE_CTL: begin
          nxt_rdata[`UGPS_RTS_LVL_BIT] = cfg_ff[c].rts_level;
        end
        `UGPS_REG_TX_SYNC: begin
          nxt_rdata[`UGPS_FUNC_SEL_BIT] = cfg_ff[c].refclk_sel;
        end
        `UGPS_REG_TIMER_UP: begin
          nxt_rdata[`UGPS_FUNC_SEL_BIT] = cfg_ff[c].timer_sel;
        end
        `UGPS_REG_CLK_SRC: begin
          nxt_rdata[`UGPS_FUNC_SEL_BIT] = cfg_ff[c].clksrc_sel;
        end
        `UGPS_REG_INT_CLR: begin
          // write-only: reads zero
          nxt_rdata = 8'h00;
        end
        `UGPS_REG_STATUS: begin
          nxt_rdata[`UGPS_STS_CTS_BIT] = cts_sync_ff[c];
          nxt_rdata[`UGPS_STS_RX_BIT]  = rx_sync_ff[c];
        end
        default: begin
          // unmapped register indices read zero
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  // read data register
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // pin source selection per channel
  always_comb begin
    logic ded;
    logic ded_val;
    int   p;
    ded     = 1'b0;
    ded_val = 1'b0;
    p       = 0;
    // defaults; every bit is set again in the loop
    nxt_gpio_out  = '0;
    nxt_gpio_oe_n = '1;
    nxt_tx        = '0;
    nxt_rts_n     = '1;
    for (int c = 0; c < NUM_CHAN; c++) begin
      nxt_tx[c] = TX_DATA[c];
      // baud clock has priority over level
      if (cfg_ff[c].clksrc_sel) begin
        nxt_rts_n[c] = BAUD_CLK[c];
      end else begin
        nxt_rts_n[c] = cfg_ff[c].rts_level;
      end
      // walk the pins of this group
      for (int i = 0; i < PINS; i++) begin
        p = c * PINS + i;
        // refclk on first pin of every group
        ded = (i == `UGPS_REFCLK_PIN && cfg_ff[c].refclk_sel) ||
              (i == `UGPS_TIMER_PIN && cfg_ff[c].timer_sel);
        ded_val = (i == `UGPS_REFCLK_PIN) ? REF_CLK[c] : TIMER_OUT[c];
        // dedicated drive ignores the open-drain bit
        // dedicated function wins, gpio state kept
        if (ded) begin
          nxt_gpio_out[p]  = ded_val;
          nxt_gpio_oe_n[p] = 1'b0;
        end else if (cfg_ff[c].dir[i]) begin
          if (cfg_ff[c].od[i]) begin
            nxt_gpio_out[p]  = 1'b0;
            nxt_gpio_oe_n[p] = cfg_ff[c].val[i];
          end else begin
            nxt_gpio_out[p]  = cfg_ff[c].val[i];
            nxt_gpio_oe_n[p] = 1'b0;
          end
        end else begin
          nxt_gpio_out[p]  = 1'b0;
          nxt_gpio_oe_n[p] = 1'b1;
        end
      end
    end
  end

  // output flops; clocks through here gain one cycle of delay
  // tx rests high, an idle line, while in reset
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      gpio_out_ff  <= '0;
      gpio_oe_n_ff <= '1;
      tx_ff        <= '1;
      rts_n_ff     <= '1;
    end else begin
      gpio_out_ff  <= nxt_gpio_out;
      gpio_oe_n_ff <= nxt_gpio_oe_n;
      tx_ff        <= nxt_tx;
      rts_n_ff     <= nxt_rts_n;
    end
  end

  // bus side: ports straight from flops
  assign RDATA      = rdata_ff;
  assign IRQ        = irq_ff;

  // pin side
  assign TX         = tx_ff;
  assign RTS_N      = rts_n_ff;
  assign GPIO_OUT   = gpio_out_ff;
  assign GPIO_OE_N  = gpio_oe_n_ff;
  assign CTS_N_CORE = cts_sync_ff;
  assign RX_CORE    = rx_sync_ff;

endmodule : ugps_pin_select

// File: testbench/ugps_monitor.sv
// Purpose: port checker of the pin select
// Assumes: select bits mirrored from bus writes
// Notes:   pins checked one edge after the register
`timescale 1ns/1ps
module ugps_monitor #(
  parameter int NUM_CHAN = 4,
  parameter int PINS     = 4
) (
  input wire logic                       CORE_CLK,
  input wire logic                       RESET,
  input wire ugps_pkg::ugps_addr_t       ADDR,
  input wire logic [7:0]                 WDATA,
  input wire logic                       WR,
  input wire logic [NUM_CHAN-1:0]        TX_DATA,
  input wire logic [NUM_CHAN-1:0]        REF_CLK,
  input wire logic [NUM_CHAN-1:0]        TIMER_OUT,
  input wire logic [NUM_CHAN-1:0]        BAUD_CLK,
  input wire logic [NUM_CHAN-1:0]        TX,
  input wire logic [NUM_CHAN-1:0]        RTS_N,
  input wire logic [NUM_CHAN-1:0]        CTS_N,
  input wire logic [NUM_CHAN-1:0]        RX,
  input wire logic [NUM_CHAN-1:0]        CTS_N_CORE,
  input wire logic [NUM_CHAN-1:0]        RX_CORE,
  input wire logic [NUM_CHAN*PINS-1:0]   GPIO_OUT,
  input wire logic [NUM_CHAN*PINS-1:0]   GPIO_OE_N,
  input wire logic                       IRQ
);
  import ugps_pkg::*;
  logic [NUM_CHAN-1:0] ref_ff, tmr_ff, clk_ff, lvl_ff, p0_out, p0_oen, p1_out, p1_oen;
  // first two pins of each group
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_pin
    assign p0_out[c] = GPIO_OUT[c*PINS];
    assign p0_oen[c] = GPIO_OE_N[c*PINS];
    assign p1_out[c] = GPIO_OUT[c*PINS+1];
    assign p1_oen[c] = GPIO_OE_N[c*PINS+1];
  end
  // mirror of select bits, needed since registers are not ports
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      {ref_ff, tmr_ff, clk_ff} <= '0;
      lvl_ff <= '1;
    end else if (WR) begin
      case (ADDR.reg_idx)
        4'h5: lvl_ff[ADDR.chan] <= WDATA[1];
        4'h6: ref_ff[ADDR.chan] <= WDATA[7];
        4'h7: tmr_ff[ADDR.chan] <= WDATA[7];
        4'h8: clk_ff[ADDR.chan] <= WDATA[7];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  tx_follow_a: assert property (!$past(RESET) |-> TX == $past(TX_DATA))
    else $error("tx not one cycle behind its source");
  cts_sync_a: assert property (!$past(RESET) && !$past(RESET, 2) |-> CTS_N_CORE == $past(CTS_N, 2))
    else $error("cts sample wrong");
  rx_sync_a: assert property (!$past(RESET) && !$past(RESET, 2) |-> RX_CORE == $past(RX, 2))
    else $error("rx sample wrong");
  rts_level_a: assert property ((RTS_N & ~$past(clk_ff)) == ($past(lvl_ff) & ~$past(clk_ff)))
    else $error("rts level differs from software");
  rts_clock_a: assert property ((RTS_N & $past(clk_ff)) == ($past(BAUD_CLK) & $past(clk_ff)))
    else $error("rts does not carry baud clock");
  refclk_pin_a: assert property ((p0_out & $past(ref_ff)) == ($past(REF_CLK) & $past(ref_ff)))
    else $error("pin 0 does not carry reference clock");
  timer_pin_a: assert property ((p1_out & $past(tmr_ff)) == ($past(TIMER_OUT) & $past(tmr_ff)))
    else $error("pin 1 does not carry timer");
  ded_drive_a: assert property (((p0_oen & $past(ref_ff)) | (p1_oen & $past(tmr_ff))) == '0)
    else $error("dedicated pin not driven");
  cover property (clk_ff != '0);
  cover property ($rose(IRQ));
  cover property (ref_ff != '0 && tmr_ff != '0);
endmodule : ugps_monitor

bind ugps_pin_select ugps_monitor #(.NUM_CHAN(NUM_CHAN), .PINS(PINS)) ugps_monitor_i (
  .CORE_CLK   (CORE_CLK),
  .RESET      (RESET),
  .ADDR       (ADDR),
  .WDATA      (WDATA),
  .WR         (WR),
  .TX_DATA    (TX_DATA),
  .REF_CLK    (REF_CLK),
  .TIMER_OUT  (TIMER_OUT),
  .BAUD_CLK   (BAUD_CLK),
  .TX         (TX),
  .RTS_N      (RTS_N),
  .CTS_N      (CTS_N),
  .RX         (RX),
  .CTS_N_CORE (CTS_N_CORE),
  .RX_CORE    (RX_CORE),
  .GPIO_OUT   (GPIO_OUT),
  .GPIO_OE_N  (GPIO_OE_N),
  .IRQ        (IRQ)
);

// File: testbench/ugps_far_model.sv
// Purpose: transceivers and peripherals on the pins
// Assumes: gpio lines have pull-downs
// Notes:   external drive yields to the device
`timescale 1ns/1ps
module ugps_far_model (
  input  wire logic [15:0] gpio_out,
  input  wire logic [15:0] gpio_oe_n,
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  input  wire logic [3:0]  cts_req,
  input  wire logic [3:0]  rx_line,
  output logic      [15:0] gpio_in,
  output logic      [3:0]  cts_n,
  output logic      [3:0]  rx
);
  // wire level: released lines fall to the pull-down
  always_comb begin
    for (int p = 0; p < 16; p++) begin
      gpio_in[p] = !gpio_oe_n[p] ? gpio_out[p] : (ext_en[p] & ext_val[p]);
    end
  end
  assign cts_n = ~cts_req;
  assign rx = rx_line;
endmodule : ugps_far_model

// File: testbench/tb.sv
// Purpose: self-checking bench of the pin select
// Assumes: far side modelled by ugps_far_model
// Notes:   sources count freely every cycle
`timescale 1ns/1ps
module tb;
  import ugps_pkg::*;
  logic CORE_CLK = 0, RESET = 1, WR = 0, RD = 0, IRQ;
  ugps_addr_t ADDR = '0;
  logic [7:0] WDATA = '0, RDATA;
  logic [15:0] src = '0, ext_val = '0, ext_en = '0, GPIO_IN, GPIO_OUT, GPIO_OE_N;
  logic [3:0] cts_req = '0, rx_line = '1, TX, RTS_N, CTS_N, RX, CTS_N_CORE, RX_CORE;
  int error_cnt = 0, checks_done = 0;
  ugps_pin_select ugps_pin_select_i (.CORE_CLK(CORE_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TX_DATA(src[3:0]), .REF_CLK(src[7:4]), .TIMER_OUT(src[11:8]),
    .BAUD_CLK(src[15:12]), .TX(TX), .RTS_N(RTS_N), .CTS_N(CTS_N), .RX(RX), .CTS_N_CORE(CTS_N_CORE),
    .RX_CORE(RX_CORE), .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT), .GPIO_OE_N(GPIO_OE_N), .IRQ(IRQ));
  ugps_far_model ugps_far_model_i (.gpio_out(GPIO_OUT), .gpio_oe_n(GPIO_OE_N), .ext_val(ext_val),
    .ext_en(ext_en), .cts_req(cts_req), .rx_line(rx_line), .gpio_in(GPIO_IN), .cts_n(CTS_N), .rx(RX));
  // clock and free-running sources
  initial forever #10 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) src <= src + 16'h1357;
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] c, input logic [3:0] i, input logic [7:0] d);
    @(posedge CORE_CLK);
    ADDR <= {c, i};
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] c, input logic [3:0] i, input logic [7:0] exp);
    @(posedge CORE_CLK);
    ADDR <= {c, i};
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1 chk("rdata", RDATA, exp);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask : tick
  task automatic t_gpio;
    wr(2'h1, 4'h0, 8'h04);
    wr(2'h1, 4'h1, 8'h04);
    tick(1);
    chk("push_pull", {GPIO_OE_N[6], GPIO_OUT[6]}, 2'b01);
    wr(2'h1, 4'h0, 8'h44);
    tick(1);
    chk("od_release", {GPIO_OE_N[6], GPIO_IN[6]}, 2'b10);
    wr(2'h1, 4'h1, 8'h00);
    tick(1);
    chk("od_low", {GPIO_OE_N[6], GPIO_OUT[6]}, 2'b00);
    wr(2'h1, 4'h0, 8'h00);
    ext_en <= 16'h0040;
    ext_val <= 16'h0040;
    tick(2);
    rd(2'h1, 4'h1, 8'h04);
  endtask : t_gpio
  task automatic t_irq;
    wr(2'h2, 4'h2, 8'h01);
    ext_en[8] <= 1'b1;
    ext_val[8] <= 1'b1;
    tick(5);
    chk("irq_set", IRQ, 1'b1);
    rd(2'h2, 4'h3, 8'h01);
    wr(2'h2, 4'h4, 8'h01);
    tick(2);
    chk("irq_clear", IRQ, 1'b0);
    wr(2'h2, 4'h2, 8'h00);
    ext_val[8] <= 1'b0;
    tick(5);
    chk("irq_mask", IRQ, 1'b0);
    rd(2'h2, 4'h3, 8'h01);
    wr(2'h2, 4'h4, 8'h01);
  endtask : t_irq
  task automatic t_line;
    logic [15:0] prev;
    wr(2'h3, 4'h5, 8'h00);
    cts_req[3] <= 1'b1;
    rx_line[3] <= 1'b0;
    tick(2);
    prev = src - 16'h1357;
    chk("rts_low", RTS_N, 4'h7);
    chk("tx", TX, prev[3:0]);
    chk("cts_core", CTS_N_CORE, 4'h7);
    chk("rx_core", RX_CORE, 4'h7);
    rd(2'h3, 4'h9, 8'h00);
    rd(2'h0, 4'h9, 8'h03);
    wr(2'h3, 4'h5, 8'h02);
    tick(1);
    chk("rts_high", RTS_N, 4'hF);
  endtask : t_line
  task automatic t_ded;
    logic [15:0] prev;
    wr(2'h0, 4'h0, 8'h01);
    wr(2'h0, 4'h1, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(2'(c), 4'h6, 8'h80);
      wr(2'(c), 4'h7, 8'h80);
      wr(2'(c), 4'h8, 8'h80);
    end
    tick(1);
    prev = src - 16'h1357;
    chk("ded_oe", GPIO_OE_N & 16'h3333, 16'h0000);
    chk("refclk", {GPIO_OUT[12], GPIO_OUT[8], GPIO_OUT[4], GPIO_OUT[0]}, prev[7:4]);
    chk("timer", {GPIO_OUT[13], GPIO_OUT[9], GPIO_OUT[5], GPIO_OUT[1]}, prev[11:8]);
    chk("rts_clk", RTS_N, prev[15:12]);
    for (int c = 0; c < 4; c++) begin
      wr(2'(c), 4'h6, 8'h00);
      wr(2'(c), 4'h7, 8'h00);
      wr(2'(c), 4'h8, 8'h00);
    end
    tick(1);
    chk("restore", {GPIO_OE_N, GPIO_OUT[0], RTS_N}, {16'hFFFE, 1'b1, 4'hF});
  endtask : t_ded
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RESET <= 1'b0;
    tick(1);
    chk("rst_pins", {GPIO_OE_N, RTS_N, IRQ}, {16'hFFFF, 4'hF, 1'b0});
    t_gpio;
    t_irq;
    t_line;
    t_ded;
    end_sim;
  end
  // watchdog, over twenty times the expected run
  initial begin
    repeat (3000) @(posedge CORE_CLK);
    error_cnt++;
    end_sim;
  end
endmodule : tb
